//--- logic/ee_consts.vh
// Constants shared by the serial memory front end
//
// Contract
// - Store 2048 bytes, eight bits each.
// - Select, clock, data in, data out lines.
// - Self-timed programming overwrites bytes without erase.
// - One cycle programs one to sixteen bytes.
// - Status reads answer with busy while programming.
// - Block-protect field picks four protection levels.
// - Separate commands set and clear write latch.
// - Write-protect pin refuses all programming.
// - Suspend input pauses transfer, keeps its place.
// - Only the selected device responds.
// - Opcode 00000110 sets the write latch.
// - Opcode 00000100 clears the write latch.
`ifndef EE_CONSTS_VH
`define EE_CONSTS_VH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define EE_ADDR_W      11
`define EE_MEM_DEPTH   2048
`define EE_PAGE_W      4
`define EE_PAGE_BYTES  16

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define EE_OP_LATCH_SET 8'h06
`define EE_OP_LATCH_CLR 8'h04
`define EE_OP_STAT_RD   8'h05
`define EE_OP_STAT_WR   8'h01
`define EE_OP_MEM_RD    8'h03
`define EE_OP_MEM_WR    8'h02

// ----------------------------------------------------------------
// Block protect levels and the lowest protected address of each
// ----------------------------------------------------------------
`define EE_BP_NONE     2'h0
`define EE_BP_QUARTER  2'h1
`define EE_BP_HALF     2'h2
`define EE_BASE_QUART  11'h600
`define EE_BASE_HALF   11'h400

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_CLK_NS      100
`define EE_CLK_KHZ     10000
`define EE_TWP_MS      10
`define EE_TCSH_NS     240
`define EE_TCSH_CYC    ((`EE_TCSH_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EE_SYNC_HI     2'h3
`define EE_SYNC_LO     2'h0

`endif

//--- logic/ee_buf2.v
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/10ps
module ee_buf2 (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // Filling side
    input  wire       in_valid,
    output wire       in_ready,
    input  wire [7:0] in_data,
    // Draining side
    output wire       out_valid,
    input  wire       out_ready,
    output wire [7:0] out_data
);

    reg [7:0] slot0;
    reg [7:0] slot1;
    reg [1:0] count;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot0;

    // ----------------------------------------------------------------
    // Slot 0 is always the head; slot 1 moves up on a pop
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot0 <= 8'h00;
            slot1 <= 8'h00;
            count <= 2'h0;
        end else if (ce) begin
            if (pop) begin
                slot0 <= (count == 2'h2) ? slot1 : in_data;
                if (push && count == 2'h2)
                    slot1 <= in_data;
            end else if (push) begin
                if (count == 2'h0)
                    slot0 <= in_data;
                else
                    slot1 <= in_data;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // ee_buf2

//--- logic/ee_front.v
// Serial front end and array of a 2048 x 8 nonvolatile memory
`timescale 1ns/10ps
`include "ee_consts.vh"
module ee_front #(
    parameter [16:0] WRITE_CYCLES = `EE_TWP_MS * `EE_CLK_KHZ
) (
    // Clock, reset, enable
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // Serial pins
    input  wire       cs_n,
    input  wire       sck,
    input  wire       si,
    output reg        so,
    output reg        so_oe_n,
    input  wire       wp_n,
    input  wire       hold_n,
    // Status outputs
    output reg        busy,
    output reg        write_latch,
    output reg  [1:0] block_protect,
    output reg        rx_overrun
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_AHI  = 3'h1;
    localparam [2:0] ST_ALO  = 3'h2;
    localparam [2:0] ST_WDAT = 3'h3;
    localparam [2:0] ST_RDAT = 3'h4;
    localparam [2:0] ST_SOUT = 3'h5;
    localparam [2:0] ST_SWR  = 3'h6;
    localparam [2:0] ST_SKIP = 3'h7;
    // Storage: main array and the page being gathered
    reg [7:0] mem [0:`EE_MEM_DEPTH-1];
    reg [7:0] page [0:`EE_PAGE_BYTES-1];
    reg [1:0] cs_s, sck_s, si_s, hold_s, wp_s;
    reg       sck_d, sel_d, frame_open;
    reg [2:0] bit_cnt;
    reg [6:0] rx_sh;
    reg       rx_valid;
    reg [7:0] rx_byte;
    reg [1:0] cshi_cnt;
    reg [2:0] st;
    reg       wr_cmd, out_on;
    reg [`EE_ADDR_W-1:0] addr;
    reg [`EE_ADDR_W-`EE_PAGE_W-1:0] pg_base;
    reg [`EE_PAGE_W-1:0] pg_idx;
    reg [`EE_PAGE_BYTES-1:0] pg_mask;
    reg [7:0]  tx;
    reg [16:0] wcnt;
    reg [4:0]  copy_idx;
    wire       buf_in_ready, buf_valid;
    wire [7:0] buf_data;
    // Only the selected device listens; suspend freezes the edges
    wire sel     = ~cs_s[1];
    wire hold_on = ~hold_s[1];
    wire active  = sel & ~hold_on;
    wire rise    = active & sck_s[1] & ~sck_d;
    wire fall    = active & ~sck_s[1] & sck_d;
    wire copying = busy & ~copy_idx[4];
    wire pop     = buf_valid & ~copying;
    wire [7:0] stat = {4'h0, block_protect, write_latch, busy};
    wire [`EE_ADDR_W-1:0] full_addr = {addr[10:8], buf_data};
    // Block protect: is this address inside the guarded region
    function prot;
        input [`EE_ADDR_W-1:0] a;
        input [1:0]            bp;
        begin
            case (bp)
                `EE_BP_NONE:    prot = 1'b0;
                `EE_BP_QUARTER: prot = (a >= `EE_BASE_QUART);
                `EE_BP_HALF:    prot = (a >= `EE_BASE_HALF);
                default:        prot = 1'b1;
            endcase
        end
    endfunction
    // ----------------------------------------------------------------
    // Pin synchronisers; only stage 1 is ever read by logic
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s   <= `EE_SYNC_HI;
            sck_s  <= `EE_SYNC_LO;
            si_s   <= `EE_SYNC_LO;
            hold_s <= `EE_SYNC_HI;
            wp_s   <= `EE_SYNC_HI;
            sck_d  <= 1'b0;
            sel_d  <= 1'b0;
        end else if (ce) begin
            cs_s   <= {cs_s[0], cs_n};
            sck_s  <= {sck_s[0], sck};
            si_s   <= {si_s[0], si};
            hold_s <= {hold_s[0], hold_n};
            wp_s   <= {wp_s[0], wp_n};
            sck_d  <= sck_s[1];
            sel_d  <= sel;
        end
    end

    // ----------------------------------------------------------------
    // Byte assembly on rising serial clock, MSB first
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt    <= 3'h0;
            rx_sh      <= 7'h00;
            rx_valid   <= 1'b0;
            rx_byte    <= 8'h00;
            rx_overrun <= 1'b0;
        end else if (ce) begin
            rx_valid   <= 1'b0;
            rx_overrun <= rx_valid & ~buf_in_ready;
            if (!sel) begin
                bit_cnt <= 3'h0;
            end else if (rise) begin
                rx_sh   <= {rx_sh[5:0], si_s[1]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    rx_valid <= 1'b1;
                    rx_byte  <= {rx_sh, si_s[1]};
                end
            end
        end
    end

    // Decoder stalls while the array port is busy copying the page
    ee_buf2 u_buf (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (rx_valid),
        .in_ready  (buf_in_ready),
        .in_data   (rx_byte),
        .out_valid (buf_valid),
        .out_ready (~copying),
        .out_data  (buf_data)
    );

    // ----------------------------------------------------------------
    // Array write port: page copy in the first cycles of programming
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (ce && copying && pg_mask[copy_idx[3:0]])
            mem[{pg_base, copy_idx[3:0]}] <= page[copy_idx[3:0]];
    end

    // Page gather: a wrap inside the page overwrites earlier bytes
    always @(posedge clk) begin
        if (ce && pop && st == ST_WDAT)
            page[pg_idx] <= buf_data;
    end

    // ----------------------------------------------------------------
    // Command decoder, latch, protection, programming timer
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st            <= ST_IDLE;
            frame_open    <= 1'b0;
            cshi_cnt      <= 2'h0;
            wr_cmd        <= 1'b0;
            out_on        <= 1'b0;
            addr          <= 11'h000;
            pg_base       <= 7'h00;
            pg_idx        <= 4'h0;
            pg_mask       <= 16'h0000;
            tx            <= 8'h00;
            so            <= 1'b0;
            so_oe_n       <= 1'b1;
            busy          <= 1'b0;
            write_latch   <= 1'b0;
            block_protect <= `EE_BP_NONE;
            wcnt          <= 17'h00000;
            copy_idx      <= 5'h10;
        end else if (ce) begin
            // Output only while selected, not suspended, and sending
            so_oe_n <= ~(out_on & active);
            // Deselect time is counted so a too-short gap is refused
            if (!sel && cshi_cnt != `EE_TCSH_CYC)
                cshi_cnt <= cshi_cnt + 2'h1;
            if (sel && !sel_d) begin
                frame_open <= 1'b1;
                cshi_cnt   <= 2'h0;
                if (cshi_cnt < `EE_TCSH_CYC)
                    st <= ST_SKIP;
            end
            // Programming timer; busy clears after the full write time
            if (busy) begin
                wcnt <= wcnt + 17'h1;
                if (copying)
                    copy_idx <= copy_idx + 5'h1;
                if (wcnt == WRITE_CYCLES - 17'h1)
                    busy <= 1'b0;
            end
            // Shift out on falling edges, but not at a byte boundary
            if (fall && out_on && bit_cnt != 3'h0) begin
                so <= tx[6];
                tx <= {tx[6:0], 1'b0};
            end
            if (pop) begin
                case (st)
                    ST_IDLE: begin
                        if (busy) begin
                            // Only status polls are served while programming
                            if (buf_data == `EE_OP_STAT_RD) begin
                                st     <= ST_SOUT;
                                out_on <= 1'b1;
                                tx     <= stat;
                                so     <= stat[7];
                            end else begin
                                st <= ST_SKIP;
                            end
                        end else begin
                            st <= ST_SKIP;
                            case (buf_data)
                                `EE_OP_LATCH_SET: write_latch <= 1'b1;
                                `EE_OP_LATCH_CLR: write_latch <= 1'b0;
                                `EE_OP_STAT_RD: begin
                                    st     <= ST_SOUT;
                                    out_on <= 1'b1;
                                    tx     <= stat;
                                    so     <= stat[7];
                                end
                                `EE_OP_STAT_WR: begin
                                    if (write_latch && wp_s[1])
                                        st <= ST_SWR;
                                end
                                `EE_OP_MEM_RD: begin
                                    st     <= ST_AHI;
                                    wr_cmd <= 1'b0;
                                end
                                `EE_OP_MEM_WR: begin
                                    if (write_latch && wp_s[1]) begin
                                        st     <= ST_AHI;
                                        wr_cmd <= 1'b1;
                                    end
                                end
                                default: st <= ST_SKIP;
                            endcase
                        end
                    end
                    ST_AHI: begin
                        addr[10:8] <= buf_data[2:0];
                        st         <= ST_ALO;
                    end
                    ST_ALO: begin
                        if (wr_cmd) begin
                            pg_base <= full_addr[10:4];
                            pg_idx  <= full_addr[3:0];
                            pg_mask <= 16'h0000;
                            st <= prot(full_addr, block_protect) ? ST_SKIP
                                                                 : ST_WDAT;
                        end else begin
                            st     <= ST_RDAT;
                            out_on <= 1'b1;
                            tx     <= mem[full_addr];
                            so     <= mem[full_addr][7];
                            addr   <= full_addr + 11'h1;
                        end
                    end
                    ST_WDAT: begin
                        pg_mask[pg_idx] <= 1'b1;
                        pg_idx          <= pg_idx + 4'h1;
                    end
                    ST_RDAT: begin
                        tx   <= mem[addr];
                        so   <= mem[addr][7];
                        addr <= addr + 11'h1;
                    end
                    ST_SOUT: begin
                        // Repeated status bytes let the master keep polling
                        tx <= stat;
                        so <= stat[7];
                    end
                    ST_SWR: begin
                        block_protect <= buf_data[3:2];
                        write_latch   <= 1'b0;
                        st            <= ST_SKIP;
                    end
                    default: st <= ST_SKIP;
                endcase
            end
            // Frame end, once every received byte is decoded
            if (!sel && frame_open && !buf_valid) begin
                frame_open <= 1'b0;
                out_on     <= 1'b0;
                st         <= ST_IDLE;
                if (st == ST_WDAT && pg_mask != 16'h0000) begin
                    busy        <= 1'b1;
                    wcnt        <= 17'h00000;
                    copy_idx    <= 5'h00;
                    write_latch <= 1'b0;
                end
            end
        end
    end
endmodule // ee_front

//--- test/ee_front_monitor.sv
// Pin-level assertions for the serial memory front end
`timescale 1ns/10ps
module ee_front_monitor #(
    parameter [16:0] WRITE_CYCLES = 17'd100000
) (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Serial pins
    input wire       cs_n,
    input wire       hold_n,
    input wire       wp_n,
    input wire       so_oe_n,
    // Status
    input wire       busy,
    input wire       write_latch,
    input wire [1:0] block_protect
);
    // ------------------------------------------
    // Helper: length of the current busy stretch
    // ------------------------------------------
    reg [16:0] busy_len;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_len <= 17'h0;
        end else begin
            busy_len <= busy ? busy_len + 17'h1 : 17'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------
    // Properties
    // ------------------------------------------
    // Sync delay allows a few cycles before release
    property p_desel_hiz;
        cs_n [*5] |-> so_oe_n;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("so driven while idle");
    property p_hold_hiz;
        !hold_n [*5] |-> so_oe_n;
    endproperty
    a_hold_hiz: assert property (p_hold_hiz) else $error("so driven in suspend");
    property p_oe_sel;
        $fell(so_oe_n) |-> !cs_n && hold_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("so enabled unselected");
    property p_busy_len;
        $fell(busy) |-> busy_len >= WRITE_CYCLES - 17'h1 && busy_len <= WRITE_CYCLES + 17'h1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length");
    property p_busy_cs;
        $rose(busy) |-> cs_n && $past(cs_n, 2);
    endproperty
    a_busy_cs: assert property (p_busy_cs) else $error("program before frame end");
    property p_busy_wp;
        $rose(busy) |-> $past(wp_n, 4);
    endproperty
    a_busy_wp: assert property (p_busy_wp) else $error("program while protected");
    property p_busy_latch;
        $rose(busy) |-> ##[0:2] !write_latch;
    endproperty
    a_busy_latch: assert property (p_busy_latch) else $error("latch kept");
    property p_latch_set;
        $rose(write_latch) |-> !busy && !cs_n;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch set unselected");
    property p_bp_guard;
        $changed(block_protect) |-> $past(write_latch) && !busy;
    endproperty
    a_bp_guard: assert property (p_bp_guard) else $error("protect changed unlatched");
endmodule // ee_front_monitor

bind ee_front ee_front_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .clk(clk), .rst(rst), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
    .so_oe_n(so_oe_n), .busy(busy), .write_latch(write_latch),
    .block_protect(block_protect)
);

//--- test/ee_master.sv
// Serial bus master model for the memory front end
`timescale 1ns/10ps
module ee_master (
    // Clock and return line
    input  wire clk,
    input  wire so,
    // Serial drive
    output reg  cs_n,
    output reg  sck,
    output reg  si,
    output reg  hold_n
);
    // ------------------------------------------
    // Idle levels; clock stands low between frames
    // ------------------------------------------
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
    end
    // Step n clocks, then move just past the edge
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task sel;
        cs_n = 1'b0;
        tick(4);
    endtask
    // Gap g below three clocks is a deliberate violation
    task desel(input integer g);
        tick(4);
        cs_n = 1'b1;
        si = ~si; // Idle data line carries no stale bit
        tick(g);
    endtask
    // One byte, MSB first, sampled late in the high phase
    task xfer(input [7:0] tx, input hold, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            si = tx[i];
            tick(4);
            sck = 1'b1;
            tick(3);
            rx[i] = so;
            tick(1);
            sck = 1'b0;
            if (hold && i == 4) begin
                // Stray clock inside the suspend must be ignored
                tick(4);
                hold_n = 1'b0;
                tick(3);
                sck = 1'b1;
                tick(4);
                sck = 1'b0;
                tick(4);
                hold_n = 1'b1;
            end
        end
    endtask
endmodule // ee_master

//--- test/ee_front_test.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/10ps
`include "ee_consts.vh"
module ee_front_test;
    // ------------------------------------------
    // Signals
    // ------------------------------------------
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         wp_n = 1'b1;
    reg         oe;
    reg         seen;
    reg   [7:0] st;
    reg   [7:0] tx [0:19];
    reg   [7:0] rx [0:19];
    integer     error_cnt = 0;
    integer     checks = 0;
    integer     i, k, n;
    wire        cs_n, sck, si, so, so_oe_n, hold_n, busy, write_latch;
    wire  [1:0] block_protect;
    wire        rx_overrun;
    reg         ovr_seen = 1'b0;

    always #50 clk = ~clk;

    // Any dropped byte is latched for the closing check
    always @(posedge clk) begin
        if (rx_overrun === 1'b1)
            ovr_seen <= 1'b1;
    end

    // Write cycle long enough to span a status poll
    ee_front #(.WRITE_CYCLES(17'd400)) u_dut (
        .clk(clk), .rst(rst), .ce(1'b1), .cs_n(cs_n), .sck(sck), .si(si),
        .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .hold_n(hold_n), .busy(busy),
        .write_latch(write_latch), .block_protect(block_protect), .rx_overrun(rx_overrun)
    );
    // Released output line reads as the inverse
    ee_master u_mst (
        .clk(clk), .so(so_oe_n ? ~so : so), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n)
    );

    task chk(input [7:0] g, input [7:0] e);
        checks = checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task done(input integer t);
        $display("test %0d finished", t);
    endtask
    // Frame of m bytes from tx; byte h is suspended
    task run(input integer m, input integer h);
        integer j;
        u_mst.sel;
        for (j = 0; j < m; j = j + 1) u_mst.xfer(tx[j], j == h, rx[j]);
        oe = so_oe_n;
        u_mst.desel(4);
    endtask
    task op(input [7:0] c);
        tx[0] = c;
        run(1, -1);
    endtask
    task status;
        tx[0] = `EE_OP_STAT_RD;
        tx[1] = 8'h00;
        run(2, -1);
        st = rx[1];
    endtask
    task wr(input [10:0] a, input integer m, input [7:0] b, input en);
        if (en) op(`EE_OP_LATCH_SET);
        tx[0] = `EE_OP_MEM_WR;
        tx[1] = {5'h00, a[10:8]};
        tx[2] = a[7:0];
        for (k = 0; k < m; k = k + 1) tx[3+k] = b + k[7:0];
        run(3 + m, -1);
    endtask
    task rd(input [10:0] a, input integer m, input integer h);
        tx[0] = `EE_OP_MEM_RD;
        tx[1] = {5'h00, a[10:8]};
        tx[2] = a[7:0];
        for (k = 3; k < 3 + m; k = k + 1) tx[k] = 8'h00;
        run(3 + m, h);
    endtask
    // Poll status until ready, bounded
    task poll(input [7:0] e);
        integer p;
        p = 0;
        status;
        seen = st[0];
        while (st[0] !== 1'b0 && p < 20) begin
            status;
            p = p + 1;
        end
        if (p == 20) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t ready never shown", $time);
            results;
        end else begin
            chk(st, e);
            chk({7'h0, seen}, 8'h01);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        u_mst.tick(4);
        chk({4'h0, block_protect, write_latch, busy}, 8'h00);
        chk({7'h0, so_oe_n}, 8'h01);
        status;
        chk(st, 8'h00);
        chk({7'h0, oe}, 8'h00);
        done(1);
        // Latch commands; deaf when deselected or after a short gap
        op(`EE_OP_LATCH_SET);
        status;
        chk(st, 8'h02);
        op(`EE_OP_LATCH_CLR);
        chk({7'h0, write_latch}, 8'h00);
        u_mst.xfer(`EE_OP_LATCH_SET, 1'b0, st);
        chk({7'h0, write_latch}, 8'h00);
        u_mst.sel;
        u_mst.xfer(`EE_OP_STAT_RD, 1'b0, st);
        u_mst.desel(1);
        op(`EE_OP_LATCH_SET);
        chk({7'h0, write_latch}, 8'h00);
        done(2);
        // Unlatched write, full page, then one byte read under suspend
        wr(11'h010, 1, 8'h55, 1'b0);
        chk({7'h0, busy}, 8'h00);
        wr(11'h010, 16, 8'h30, 1'b1);
        chk({6'h0, busy, write_latch}, 8'h02);
        poll(8'h00);
        rd(11'h010, 16, -1);
        for (i = 0; i < 16; i = i + 1) chk(rx[3+i], 8'h30 + i[7:0]);
        wr(11'h013, 1, 8'ha5, 1'b1);
        poll(8'h00);
        rd(11'h012, 3, 4);
        chk(rx[3], 8'h32);
        chk(rx[4], 8'ha5);
        chk(rx[5], 8'h34);
        done(3);
        // Protect pin refuses programming, latch untouched
        wp_n = 1'b0;
        wr(11'h014, 1, 8'h77, 1'b1);
        chk({6'h0, busy, write_latch}, 8'h01);
        wp_n = 1'b1;
        rd(11'h014, 1, -1);
        chk(rx[3], 8'h34);
        op(`EE_OP_LATCH_CLR);
        done(4);
        // Every protect level against a write at the middle region
        for (n = 0; n < 4; n = n + 1) begin
            op(`EE_OP_LATCH_SET);
            tx[0] = `EE_OP_STAT_WR;
            tx[1] = {4'h0, n[1:0], 2'h0};
            run(2, -1);
            chk({6'h0, block_protect}, {6'h0, n[1:0]});
            wr(11'h500, 1, 8'h40 + n[7:0], 1'b1);
            if (n < 2)
                poll({4'h0, n[1:0], 2'h0});
            else
                chk({7'h0, busy}, 8'h00);
        end
        rd(11'h500, 1, -1);
        chk(rx[3], 8'h41);
        // No received byte was ever dropped by the buffer
        chk({7'h0, ovr_seen}, 8'h00);
        done(5);
        results;
    end
endmodule // ee_front_test
